// file: design/clk_power_mode_ctrl.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module clk_power_mode_ctrl import cpmc_pkg::*; #(
  parameter int unsigned LONG_WAIT_CYC = LONG_WAIT_CYC_DEF,
  parameter int unsigned OSC_WAIT_CYC  = OSC_WAIT_CYC_DEF
) (
  input  wire logic        aclk,              // System clock, 100 MHz
  input  wire logic        aresetn,           // Sync reset, active low
  input  wire logic [7:0]  awaddr,            // Write address
  input  wire logic [2:0]  awprot,            // Unused protection
  input  wire logic        awvalid,           // Write address valid
  output logic             awready,           // Write address ready
  input  wire logic [31:0] wdata,             // Write data
  input  wire logic [3:0]  wstrb,             // Byte enables
  input  wire logic        wvalid,            // Write data valid
  output logic             wready,            // Write data ready
  output logic [1:0]       bresp,             // Write response
  output logic             bvalid,            // Write response valid
  input  wire logic        bready,            // Write response ready
  input  wire logic [7:0]  araddr,            // Read address
  input  wire logic [2:0]  arprot,            // Unused protection
  input  wire logic        arvalid,           // Read address valid
  output logic             arready,           // Read address ready
  output logic [31:0]      rdata,             // Read data
  output logic [1:0]       rresp,             // Read response
  output logic             rvalid,            // Read data valid
  input  wire logic        rready,            // Read data ready
  input  wire logic        sleep_instruction, // CPU sleep pulse
  input  wire logic        watchdog_en,       // Watchdog enabled level
  input  wire logic        sub_osc_in,        // Sub oscillator wave
  input  wire logic        main_osc_in,       // Main oscillator wave
  input  wire logic [10:0] wake_pins,         // Port 7 [7:0], port 5 [10:8]
  output logic             cpu_run,           // CPU may execute
  output logic             cpu_clk_main,      // CPU clock source main
  output logic             main_osc_en,       // Main oscillator enable
  output logic             sub_osc_en,        // Sub oscillator enable
  output logic [7:0]       pll_mult_num,      // Multiplier numerator
  output logic [1:0]       pll_mult_shift,    // Divide by two to this power
  output logic             booster_tick,      // Charge-pump clock pulse
  output logic             tmr_fs_run,        // Sub-clocked timers may count
  output logic             tmr_fm_run,        // Main-clocked timers may count
  output logic             tmr_ext_run,       // Pin-clocked timers may count
  output logic [2:0]       mode_code          // Current power state
);
  pm_state_t         state_q;
  logic [WAIT_W-1:0] wait_cnt_q;
  logic [3:0]        edge_cnt_q;
  logic              cnt_main_q;
  logic              src_main_q;
  logic [6:0]        ctl_q;
  logic [2:0]        wake_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic [5:0]        aw_idx_q;
  logic [7:0]        wd_q;
  logic              wb0_q;
  logic [1:0]        osc_rise;
  logic [10:0]       pin_chg;
  logic              wake_hit;
  logic              edge_tick;
  logic [3:0]        edge_last;
  logic [7:0]        wake_rd;
  logic [7:0]        status_rd;

  sync_change #(.W(2)) u_osc_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  ({main_osc_in, sub_osc_in}),
    .rise    (osc_rise),
    .chg     ()
  );

  sync_change #(.W(11)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (wake_pins),
    .rise    (),
    .chg     (pin_chg)
  );

  tick_divider u_booster (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (osc_rise[0]),
    .sel      (ctl_q[BF_LSB +: 2]),
    .tick_out (booster_tick)
  );

  // Timer matches are not wake sources, only pin groups are
  assign wake_hit = (!wake_q[2] && |pin_chg[7:4]) ||
                    (!wake_q[1] && |pin_chg[3:0]) ||
                    (!wake_q[0] && |pin_chg[10:8]);

  assign edge_tick = cnt_main_q ? osc_rise[1] : osc_rise[0];
  assign edge_last = cnt_main_q ? 4'(MAIN_EDGES - 1) : 4'(SUB_EDGES - 1);

  // Power state sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_LONG_WAIT;
      wait_cnt_q <= WAIT_W'(LONG_WAIT_CYC - 1);
      edge_cnt_q <= 4'h0;
      cnt_main_q <= 1'b0;
      src_main_q <= 1'b0;
    end else begin
      case (state_q)
        ST_LONG_WAIT: begin
          if (wait_cnt_q == '0) begin
            state_q    <= ST_OSC_WAIT;
            wait_cnt_q <= WAIT_W'(OSC_WAIT_CYC - 1);
          end else begin
            wait_cnt_q <= wait_cnt_q - 1'b1;
          end
        end
        ST_OSC_WAIT: begin
          if (wait_cnt_q == '0) begin
            state_q    <= ST_EDGE_CNT;
            edge_cnt_q <= 4'h0;
          end else begin
            wait_cnt_q <= wait_cnt_q - 1'b1;
          end
        end
        ST_EDGE_CNT: begin
          if (edge_tick) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
            if (edge_cnt_q == edge_last) begin
              state_q    <= ST_RUN;
              src_main_q <= ctl_q[CPU_SEL_BIT];
              cnt_main_q <= 1'b0;
            end
          end
        end
        ST_RUN: begin
          // Next instruction is a no-op, so stopping here loses nothing
          if (sleep_instruction) begin
            state_q    <= ctl_q[IDLE_BIT] ? ST_IDLE : ST_SLEEP;
            src_main_q <= 1'b0;
          end else if (ctl_q[CPU_SEL_BIT] && !src_main_q) begin
            state_q    <= ST_OSC_WAIT;
            wait_cnt_q <= WAIT_W'(OSC_WAIT_CYC - 1);
            cnt_main_q <= 1'b1;
          end else if (!ctl_q[CPU_SEL_BIT]) begin
            src_main_q <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (wake_hit) begin
            state_q    <= ST_LONG_WAIT;
            wait_cnt_q <= WAIT_W'(LONG_WAIT_CYC - 1);
          end
        end
        ST_IDLE: begin
          if (wake_hit) begin
            state_q    <= ST_OSC_WAIT;
            wait_cnt_q <= WAIT_W'(OSC_WAIT_CYC - 1);
          end
        end
        default: state_q <= ST_LONG_WAIT;
      endcase
    end
  end

  // Clock and timer gating outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_run      <= 1'b0;
      cpu_clk_main <= 1'b0;
      main_osc_en  <= 1'b0;
      sub_osc_en   <= 1'b1;
      tmr_fs_run   <= 1'b0;
      tmr_fm_run   <= 1'b0;
      tmr_ext_run  <= 1'b1;
    end else begin
      cpu_run      <= (state_q == ST_RUN);
      cpu_clk_main <= src_main_q;
      main_osc_en  <= ctl_q[CPU_SEL_BIT] && (state_q inside
                      {ST_OSC_WAIT, ST_EDGE_CNT, ST_RUN});
      sub_osc_en   <= (state_q != ST_SLEEP);
      tmr_fs_run   <= (state_q == ST_RUN) || (state_q == ST_IDLE);
      tmr_fm_run   <= (state_q == ST_RUN) && src_main_q;
      tmr_ext_run  <= (state_q != ST_SLEEP) || watchdog_en;
    end
  end

  // Multiplier decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_mult_num   <= MULT_X130;
      pll_mult_shift <= 2'h0;
    end else begin
      case (ctl_q[PLL_LSB +: 3])
        3'h0: begin
          pll_mult_num   <= MULT_X130;
          pll_mult_shift <= 2'h0;
        end
        3'h1: begin
          pll_mult_num   <= MULT_X65;
          pll_mult_shift <= 2'h0;
        end
        3'h2: begin
          pll_mult_num   <= MULT_X65;
          pll_mult_shift <= 2'h1;
        end
        3'h3: begin
          pll_mult_num   <= MULT_X65;
          pll_mult_shift <= 2'h2;
        end
        default: begin
          pll_mult_num   <= MULT_X244;
          pll_mult_shift <= 2'h0;
        end
      endcase
    end
  end

  assign mode_code = state_q;

  // Write channel: address and data taken in either order
  assign awready = !aw_got_q && !bvalid;
  assign wready  = !w_got_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_idx_q <= 6'h00;
      wd_q     <= 8'h00;
      wb0_q    <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        aw_idx_q <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wd_q    <= wdata[7:0];
        wb0_q   <= wstrb[0];
      end
      if (aw_got_q && w_got_q) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (aw_idx_q == IDX_SYS_CTRL || aw_idx_q == IDX_WAKE_EN ||
                     aw_idx_q == IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q  <= SYS_CTRL_RST[6:0];
      wake_q <= WAKE_EN_RST[WAKE_LSB +: 3];
    end else if (aw_got_q && w_got_q && wb0_q) begin
      if (aw_idx_q == IDX_SYS_CTRL) begin
        ctl_q <= wd_q[6:0];
      end
      if (aw_idx_q == IDX_WAKE_EN) begin
        wake_q <= wd_q[WAKE_LSB +: 3];
      end
    end
  end

  assign wake_rd   = WAKE_EN_RSVD | {4'h0, wake_q, 1'b0};
  assign status_rd = {2'b00, tmr_fm_run, src_main_q, (state_q == ST_RUN), state_q};

  // Read channel, one cycle to data
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      case (araddr[7:2])
        IDX_SYS_CTRL: rdata <= {25'h0, ctl_q};
        IDX_WAKE_EN:  rdata <= {24'h0, wake_rd};
        IDX_STATUS:   rdata <= {24'h0, status_rd};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks
  a_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && sleep_instruction && !ctl_q[IDLE_BIT] |=> state_q == ST_SLEEP)
    else $error("sleep request did not enter sleep");
  a_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && sleep_instruction && ctl_q[IDLE_BIT] |=> state_q == ST_IDLE)
    else $error("sleep request did not enter idle");
  a_mult_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_q[PLL_LSB +: 3] == 3'h3 |=> pll_mult_num == MULT_X65 && pll_mult_shift == 2'h2)
    else $error("multiplier decode wrong");
  a_mult_top: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_q[PLL_LSB + 2] |=> pll_mult_num == MULT_X244)
    else $error("multiplier top code wrong");
  a_fs_tmr_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_SLEEP ##1 state_q == ST_SLEEP |=> !tmr_fs_run)
    else $error("sub timer counts in sleep");
  a_fm_tmr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !(state_q == ST_RUN && src_main_q) |=> !tmr_fm_run)
    else $error("main timer counts outside normal");
  a_main_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_q[CPU_SEL_BIT] |=> !main_osc_en)
    else $error("main oscillator runs while sub selected");
  a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_SLEEP && !wake_hit |=> state_q == ST_SLEEP)
    else $error("left sleep without enabled pin change");
  a_long_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_SLEEP && wake_hit |=> state_q == ST_LONG_WAIT &&
    wait_cnt_q == WAIT_W'(LONG_WAIT_CYC - 1))
    else $error("sleep wake skipped long wait");
  a_gn_count: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_EDGE_CNT && cnt_main_q && osc_rise[1] &&
    edge_cnt_q == 4'(MAIN_EDGES - 1) |=> state_q == ST_RUN && src_main_q)
    else $error("green to normal count wrong");
  a_idle_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_IDLE && wake_hit |=> state_q == ST_OSC_WAIT ##1 !cpu_run)
    else $error("idle wake did not start start-up wait");

  c_sleep_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_SLEEP ##1 state_q == ST_LONG_WAIT);
  c_idle_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_IDLE ##1 state_q == ST_OSC_WAIT);
  c_green_normal: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_EDGE_CNT && cnt_main_q ##1 state_q == ST_RUN);
endmodule // clk_power_mode_ctrl

// file: inc/cpmc_pkg.sv
// Functional notes
// - Multiplier field: 000 x130, 001 x65, 010 x65/2, 011 x65/4, 1xx x244.
// - Sleep instruction enters Sleep when idle bit is 0, Idle when 1.
// - Booster field divides sub clock by 1, 4, 8 or 16.
// - Select bit 0 runs CPU from sub clock, main halted; 1 from main.
// - Sub-clocked timers stop in Sleep when watchdog was enabled.
// - Pin-clocked timer counts in Sleep with watchdog; its match never wakes.
// - Main-clocked timer stopped in Sleep/Green until CPU runs in Normal.
// - Sub-clocked timer stopped in Sleep until CPU runs in destination mode.
// - Green to Normal waits start-up time plus 11 main periods.
// - Idle to Normal waits start-up plus 15 sub periods; Sleep adds 18 ms.
// - Idle to Green same delay; Sleep to Green adds 18 ms first.
// - Any reset waits 18 ms plus start-up plus 15 sub periods.
// - Active-low wake enables on bits 3,2,1 per pin group; reset disables.
// - Start-up wait runs from oscillator enable to oscillation.
package cpmc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_LONG_WAIT_NS = 18000000;
  localparam int unsigned T_OSC_START_NS = 1000000;
  localparam int unsigned LONG_WAIT_CYC_DEF =
    (T_LONG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_WAIT_CYC_DEF =
    (T_OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SUB_EDGES = 15;
  localparam int unsigned MAIN_EDGES = 11;
  localparam int unsigned WAIT_W = 21;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYS_CTRL = 6'h0D;
  localparam logic [5:0] IDX_WAKE_EN  = 6'h10;
  localparam logic [5:0] IDX_STATUS   = 6'h11;

  localparam logic [7:0] SYS_CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_EN_RST  = 8'hFF;
  localparam logic [7:0] WAKE_EN_RSVD = 8'hF1;
  localparam int unsigned CPU_SEL_BIT = 0;
  localparam int unsigned BF_LSB      = 1;
  localparam int unsigned IDLE_BIT    = 3;
  localparam int unsigned PLL_LSB     = 4;
  localparam int unsigned WAKE_LSB    = 1;
  localparam int unsigned ST_RUN_BIT  = 3;
  localparam int unsigned ST_MAIN_BIT = 4;

  localparam logic [7:0] MULT_X130 = 8'h82;
  localparam logic [7:0] MULT_X65  = 8'h41;
  localparam logic [7:0] MULT_X244 = 8'hF4;

  localparam logic [3:0] BF_DIV1  = 4'h0;
  localparam logic [3:0] BF_DIV4  = 4'h3;
  localparam logic [3:0] BF_DIV8  = 4'h7;
  localparam logic [3:0] BF_DIV16 = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_LONG_WAIT, ST_OSC_WAIT, ST_EDGE_CNT, ST_RUN, ST_SLEEP, ST_IDLE
  } pm_state_t;
endpackage

// file: design/sync_change.sv
`timescale 1ns/1ps
module sync_change #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,    // System clock
  input  wire logic         aresetn, // Sync reset, active low
  input  wire logic [W-1:0] pin_in,  // Asynchronous inputs
  output logic      [W-1:0] rise,    // Rising edge pulse
  output logic      [W-1:0] chg      // Any edge pulse
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // Only sync_q reads meta_q
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign chg  = sync_q ^ last_q;
endmodule // sync_change

// file: design/tick_divider.sv
`timescale 1ns/1ps
module tick_divider import cpmc_pkg::*; (
  input  wire logic       aclk,     // System clock
  input  wire logic       aresetn,  // Sync reset, active low
  input  wire logic       tick_in,  // Source edge pulse
  input  wire logic [1:0] sel,      // Divide select
  output logic            tick_out  // One pulse per divided period
);
  logic [3:0] cnt_q;
  logic [3:0] last;

  always_comb begin
    case (sel)
      2'h0:    last = BF_DIV1;
      2'h1:    last = BF_DIV4;
      2'h2:    last = BF_DIV8;
      default: last = BF_DIV16;
    endcase
  end

  // A count left above a lowered ratio restarts at the next tick rather than overshooting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 4'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (cnt_q >= last);
      if (tick_in) begin
        cnt_q <= (cnt_q >= last) ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end
endmodule // tick_divider

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cpmc_pkg::*;
  localparam int LONG  = 200;
  localparam int OSC   = 10;
  localparam int SUBP  = 8;  // Sub wave period in clocks
  localparam int MAINP = 4;  // Main wave period in clocks
  localparam logic [7:0] A_CTRL = {IDX_SYS_CTRL, 2'b00};
  localparam logic [7:0] A_WAKE = {IDX_WAKE_EN, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STATUS, 2'b00};

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, pll_mult_num;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, pll_mult_shift;
  logic        sleep_instruction, watchdog_en, sub_osc_in, main_osc_in;
  logic [10:0] wake_pins;
  logic        cpu_run, cpu_clk_main, main_osc_en, sub_osc_en, booster_tick;
  logic        tmr_fs_run, tmr_fm_run, tmr_ext_run;
  logic [2:0]  mode_code;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          i, g;

  clk_power_mode_ctrl #(.LONG_WAIT_CYC(LONG), .OSC_WAIT_CYC(OSC)) u_clk_power_mode_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sleep_instruction(sleep_instruction), .watchdog_en(watchdog_en),
    .sub_osc_in(sub_osc_in), .main_osc_in(main_osc_in), .wake_pins(wake_pins),
    .cpu_run(cpu_run), .cpu_clk_main(cpu_clk_main), .main_osc_en(main_osc_en),
    .sub_osc_en(sub_osc_en), .pll_mult_num(pll_mult_num), .pll_mult_shift(pll_mult_shift),
    .booster_tick(booster_tick), .tmr_fs_run(tmr_fs_run), .tmr_fm_run(tmr_fm_run),
    .tmr_ext_run(tmr_ext_run), .mode_code(mode_code)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Oscillator waves run with their own phase and stop while disabled
  initial begin
    sub_osc_in = 1'b0;
    #3;
    forever #40 sub_osc_in = (sub_osc_en !== 1'b0) ? ~sub_osc_in : 1'b0;
  end
  initial begin
    main_osc_in = 1'b0;
    #7;
    forever #20 main_osc_in = (main_osc_en === 1'b1) ? ~main_osc_in : 1'b0;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Leading edge keeps two back-to-back calls from driving a signal twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", {24'h0, exp}, rdata);
  endtask

  // Waits for run or main-clock select; main timer must stay held meanwhile, sub timer too when fs_off
  task automatic wait_on(input bit main, input int lo, input int hi, input bit fs_off);
    int c;
    logic s;
    c = 0;
    s = 1'b0;
    while (s !== 1'b1 && c < 2000) begin
      @(posedge aclk);
      s = main ? cpu_clk_main : cpu_run;
      c++;
      if (s !== 1'b1 && (tmr_fm_run !== 1'b0 || (fs_off && tmr_fs_run !== 1'b0)))
        chk("timer hold", 32'h0, 32'h1);
    end
    chk("delay low", 32'h1, {31'h0, c >= lo});
    chk("delay high", 32'h1, {31'h0, c <= hi});
  endtask

  task automatic tick_gap(output int c);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (booster_tick !== 1'b1 && c < 400);
  endtask

  task automatic sleep_pulse;
    @(posedge aclk);
    sleep_instruction <= 1'b1;
    @(posedge aclk);
    sleep_instruction <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task end_of_test;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    sleep_instruction = 1'b0;
    watchdog_en = 1'b1;
    wake_pins = 11'h000;
    repeat (8) @(posedge aclk);
    chk("pll num", 32'd130, {24'h0, pll_mult_num});
    chk("cpu run", 32'h0, {31'h0, cpu_run});
    aresetn <= 1'b1;
    wait_on(1'b0, LONG + OSC + 14 * SUBP, LONG + OSC + 16 * SUBP + 16, 1'b1);
    rd(A_CTRL, SYS_CTRL_RST, RESP_OKAY);
    rd(A_WAKE, WAKE_EN_RST, RESP_OKAY);
    rd(8'h3C, 8'h00, RESP_SLVERR);
    wr(8'h3C, 8'h55, RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      wr(A_CTRL, 8'(i << 4), RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("pll num", (i >= 4) ? 32'd244 : (i == 0) ? 32'd130 : 32'd65, {24'h0, pll_mult_num});
      chk("pll shift", (i >= 4 || i == 0) ? 32'd0 : 32'(i - 1), {30'h0, pll_mult_shift});
    end
    rd(A_CTRL, 8'h70, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wr(A_CTRL, 8'(i << 1), RESP_OKAY);
      tick_gap(g);
      tick_gap(g);
      chk("booster gap", 32'(((i == 0) ? 1 : (4 << (i - 1))) * SUBP), 32'(g));
    end
    wr(A_CTRL, 8'h01, RESP_OKAY);
    wait_on(1'b1, OSC + 10 * MAINP, OSC + 12 * MAINP + 16, 1'b0);
    repeat (2) @(posedge aclk);
    chk("main osc on", 32'h1, {31'h0, main_osc_en});
    chk("fm timer run", 32'h1, {31'h0, tmr_fm_run});
    rd(A_STAT, 8'h3B, RESP_OKAY);
    wr(A_CTRL, 8'h00, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("cpu on main", 32'h0, {31'h0, cpu_clk_main});
    chk("main osc off", 32'h0, {31'h0, main_osc_en});
    wr(A_WAKE, 8'h00, RESP_OKAY);
    rd(A_WAKE, 8'hF1, RESP_OKAY);
    wr(A_WAKE, 8'hF7, RESP_OKAY);
    sleep_pulse();
    chk("mode", 32'd4, {29'h0, mode_code});
    chk("cpu run", 32'h0, {31'h0, cpu_run});
    chk("fs timer run", 32'h0, {31'h0, tmr_fs_run});
    chk("ext timer run", 32'h1, {31'h0, tmr_ext_run});
    chk("fm timer run", 32'h0, {31'h0, tmr_fm_run});
    chk("sub osc on", 32'h0, {31'h0, sub_osc_en});
    wake_pins[0] <= 1'b1;
    wake_pins[8] <= 1'b1;
    watchdog_en <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("mode", 32'd4, {29'h0, mode_code});
    chk("ext timer run", 32'h0, {31'h0, tmr_ext_run});
    watchdog_en <= 1'b1;
    wake_pins[4] <= 1'b1;
    wait_on(1'b0, LONG + OSC + 14 * SUBP, LONG + OSC + 16 * SUBP + 20, 1'b1);
    wr(A_WAKE, 8'hFD, RESP_OKAY);
    wr(A_CTRL, 8'h08, RESP_OKAY);
    sleep_pulse();
    chk("mode", 32'd5, {29'h0, mode_code});
    wake_pins[9] <= 1'b1;
    wait_on(1'b0, OSC + 14 * SUBP, OSC + 16 * SUBP + 20, 1'b0);
    wr(A_CTRL, 8'h09, RESP_OKAY);
    wait_on(1'b1, OSC + 10 * MAINP, OSC + 12 * MAINP + 16, 1'b0);
    sleep_pulse();
    chk("mode", 32'd5, {29'h0, mode_code});
    wake_pins[9] <= 1'b0;
    wait_on(1'b0, OSC + 14 * SUBP, OSC + 16 * SUBP + 20, 1'b0);
    repeat (2) @(posedge aclk);
    chk("cpu on main", 32'h1, {31'h0, cpu_clk_main});
    wr(A_CTRL, 8'h01, RESP_OKAY);
    sleep_pulse();
    chk("mode", 32'd4, {29'h0, mode_code});
    chk("sub osc on", 32'h0, {31'h0, sub_osc_en});
    wake_pins[9] <= 1'b1;
    wait_on(1'b0, LONG + OSC + 14 * SUBP, LONG + OSC + 16 * SUBP + 20, 1'b1);
    repeat (2) @(posedge aclk);
    chk("cpu on main", 32'h1, {31'h0, cpu_clk_main});
    chk("sub osc on", 32'h1, {31'h0, sub_osc_en});
    end_of_test();
  end
endmodule // testbench
